// File: core/gpde_pkg.sv
package gpde_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0] GPDE_IDX_PORT_D_LATCH = 8'h03;
    localparam logic [7:0] GPDE_IDX_PORT_E_LATCH = 8'h08;
    localparam logic [7:0] GPDE_IDX_PORT_D_DIRECTION = 8'h04;
    localparam logic [7:0] GPDE_IDX_PORT_D_PULLUP = 8'h05;
    localparam logic [7:0] GPDE_IDX_PORT_E_DIRECTION = 8'h09;
    localparam logic [7:0] GPDE_IDX_PERIPH_ENABLE = 8'h0A;
    localparam int GPDE_ADDR_W = 8;
    localparam int GPDE_D_W = 7;
    localparam int GPDE_E_W = 2;
    // reset values of the control registers
    localparam logic [6:0] GPDE_DIR_D_RST = 7'h00;
    localparam logic [6:0] GPDE_PUE_D_RST = 7'h00;
    localparam logic [1:0] GPDE_DIR_E_RST = 2'h0;
    localparam logic [1:0] GPDE_EN_RST = 2'h0;
    // fields of the peripheral enable register
    localparam int GPDE_EN_SERIAL_BIT = 0;
    localparam int GPDE_EN_SPI_BIT = 1;
    // port e pin positions shared with the serial unit
    localparam int GPDE_E_TX_BIT = 0;
    localparam int GPDE_E_RX_BIT = 1;
    // axi response codes
    localparam logic [1:0] GPDE_RESP_OKAY = 2'b00;
    localparam logic [1:0] GPDE_RESP_SLVERR = 2'b10;
endpackage

// File: core/gpde_pin_cell.sv
`timescale 1ns/1ps
// one pin: driver, pullup and read-back select
module gpde_pin_cell
    import gpde_pkg::*;
(
    input wire logic clk, // bus clock
    input wire logic rst, // async reset, high
    input wire logic direction, // 1 = output
    input wire logic latch, // data latch bit
    input wire logic pullup_en, // pullup enable bit
    input wire logic owned, // peripheral owns the pin
    input wire logic owner_oe, // peripheral drive enable
    input wire logic owner_out, // peripheral drive value
    input wire logic pin_in, // pin level
    output logic pin_out, // registered drive value
    output logic pin_oe, // registered drive enable
    output logic pull_on, // registered pullup control
    output logic read_bit // value a read returns
);
    logic next_oe;
    logic next_out;

    // peripheral owns direction when enabled; else direction bit decides
    always_comb begin
        next_oe = owned ? owner_oe : direction;
        next_out = owned ? owner_out : latch;
    end

    // pin drivers straight from flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_oe <= 1'b0;
            pin_out <= 1'b0;
            pull_on <= 1'b0;
        end else begin
            pin_oe <= next_oe;
            pin_out <= next_out;
            // pullup only when the pin is not driven
            pull_on <= pullup_en & ~next_oe;
        end
    end

    // direction bit always steers the read, even under peripheral control
    assign read_bit = direction ? latch : pin_in;
endmodule

// File: core/gpde_ports.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
//
// Overview of operation
// - port d direction one enables driver
// - reset clears port d direction bits
// - port d read: latch if output, pin otherwise
// - latch writes always land, input unaffected
// - seven writable port d pullup enables
// - pullup on for enabled input pins
// - pullup forced off on output pins
// - port e two pins shared with serial
// - serial owns direction; direction still selects read
// - port e bit one is serial receive
// - port e bit zero is serial transmit
// - port e direction drives; reset clears
// - port e read: latch or pin
// - spi pins ignore port d direction for drive; direction still selects read
// - reset leaves port d latch unchanged
//
module gpde_ports
    import gpde_pkg::*;
(
    input wire logic CLK, // bus clock, 20 MHz
    input wire logic RST, // async reset, high
    input wire logic [7:0] S_AXI_AWADDR, // write address
    input wire logic S_AXI_AWVALID, // write address valid
    output logic S_AXI_AWREADY, // write address ready
    input wire logic [31:0] S_AXI_WDATA, // write data
    input wire logic [3:0] S_AXI_WSTRB, // write strobes
    input wire logic S_AXI_WVALID, // write data valid
    output logic S_AXI_WREADY, // write data ready
    output logic [1:0] S_AXI_BRESP, // write response
    output logic S_AXI_BVALID, // write response valid
    input wire logic S_AXI_BREADY, // write response ready
    input wire logic [7:0] S_AXI_ARADDR, // read address
    input wire logic S_AXI_ARVALID, // read address valid
    output logic S_AXI_ARREADY, // read address ready
    output logic [31:0] S_AXI_RDATA, // read data
    output logic [1:0] S_AXI_RRESP, // read response
    output logic S_AXI_RVALID, // read data valid
    input wire logic S_AXI_RREADY, // read data ready
    input wire logic [6:0] PORT_D_IN, // port d pin levels
    output logic [6:0] PORT_D_OUT, // port d drive values
    output logic [6:0] PORT_D_OE, // port d drive enables
    output logic [6:0] PORT_D_PULLUP, // port d pullup controls
    input wire logic [1:0] PORT_E_IN, // port e pin levels
    output logic [1:0] PORT_E_OUT, // port e drive values
    output logic [1:0] PORT_E_OE, // port e drive enables
    input wire logic SERIAL_TX, // serial unit transmit data
    output logic SERIAL_RX, // receive data to serial unit
    input wire logic [6:0] SPI_OWN, // pins the spi uses when enabled
    input wire logic [6:0] SPI_OE, // spi drive enables
    input wire logic [6:0] SPI_OUT, // spi drive values
    output logic SERIAL_UNIT_ENABLE, // serial enable, to serial unit
    output logic SPI_MODULE_ENABLE // spi enable, to spi module
);
    logic [6:0] port_d_latch;
    logic [6:0] port_d_direction;
    logic [6:0] port_d_pullup_enable;
    logic [1:0] port_e_latch;
    logic [1:0] port_e_direction;
    logic [1:0] periph_enable;
    logic serial_unit_enable;
    logic spi_module_enable;
    logic [6:0] d_read;
    logic [1:0] e_read;
    logic [1:0] e_pull_unused;
    logic [6:0] d_own;
    logic [1:0] e_own;
    logic [1:0] e_owner_oe;
    logic [1:0] e_owner_out;

    // write channel state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic next_aw_held;
    logic next_w_held;
    logic next_bvalid;
    logic [7:0] wr_byte;
    logic wr_lane0;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] rd_byte;
    logic [31:0] next_rdata;

    assign serial_unit_enable = periph_enable[GPDE_EN_SERIAL_BIT];
    assign spi_module_enable = periph_enable[GPDE_EN_SPI_BIT];

    // capture address and data in either order; respond after both
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    assign wr_go = aw_held && w_held && !S_AXI_BVALID;
    assign next_aw_held = (S_AXI_AWVALID && S_AXI_AWREADY)
        || (aw_held && !wr_go);
    assign next_w_held = (S_AXI_WVALID && S_AXI_WREADY)
        || (w_held && !wr_go);
    assign next_bvalid = wr_go || (S_AXI_BVALID && !S_AXI_BREADY);

    // ready flags as flops, computed from the next held state, so a
    // second word cannot slip in while one waits for its response
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
        end else begin
            S_AXI_AWREADY <= !next_aw_held && !next_bvalid;
            S_AXI_WREADY <= !next_w_held && !next_bvalid;
        end
    end
    assign wr_byte = {aw_addr[7:2], 2'b00};
    assign wr_lane0 = w_strb[0];

    // decode of mapped byte addresses
    function automatic logic gpde_mapped(input logic [7:0] a);
        logic hit;
        hit = (a == {GPDE_IDX_PORT_D_LATCH[5:0], 2'b00})
            || (a == {GPDE_IDX_PORT_E_LATCH[5:0], 2'b00})
            || (a == {GPDE_IDX_PORT_D_DIRECTION[5:0], 2'b00})
            || (a == {GPDE_IDX_PORT_D_PULLUP[5:0], 2'b00})
            || (a == {GPDE_IDX_PORT_E_DIRECTION[5:0], 2'b00})
            || (a == {GPDE_IDX_PERIPH_ENABLE[5:0], 2'b00});
        return hit;
    endfunction

    assign wr_hit = gpde_mapped(wr_byte);

    // write response: okay on mapped, slverr on unmapped
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= GPDE_RESP_OKAY;
        end else if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? GPDE_RESP_OKAY : GPDE_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // data latches carry no reset: contents survive a reset
    always_ff @(posedge CLK) begin
        if (wr_go && wr_lane0) begin
            if (wr_byte == {GPDE_IDX_PORT_D_LATCH[5:0], 2'b00}) begin
                port_d_latch <= w_data[6:0];
            end
            if (wr_byte == {GPDE_IDX_PORT_E_LATCH[5:0], 2'b00}) begin
                port_e_latch <= w_data[1:0];
            end
        end
    end

    // control registers; reset makes every pin an input
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            port_d_direction <= GPDE_DIR_D_RST;
            port_d_pullup_enable <= GPDE_PUE_D_RST;
            port_e_direction <= GPDE_DIR_E_RST;
            periph_enable <= GPDE_EN_RST;
        end else if (wr_go && wr_lane0) begin
            case (wr_byte)
                {GPDE_IDX_PORT_D_DIRECTION[5:0], 2'b00}: begin
                    port_d_direction <= w_data[6:0];
                end
                {GPDE_IDX_PORT_D_PULLUP[5:0], 2'b00}: begin
                    port_d_pullup_enable <= w_data[6:0];
                end
                {GPDE_IDX_PORT_E_DIRECTION[5:0], 2'b00}: begin
                    port_e_direction <= w_data[1:0];
                end
                {GPDE_IDX_PERIPH_ENABLE[5:0], 2'b00}: begin
                    periph_enable <= w_data[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // port d pins; spi takes pins it names only while enabled
    assign d_own = spi_module_enable ? SPI_OWN : 7'h00;
    genvar gi;
    generate
        for (gi = 0; gi < GPDE_D_W; gi = gi + 1) begin : g_port_d
            gpde_pin_cell u_cell (
                .clk(CLK),
                .rst(RST),
                .direction(port_d_direction[gi]),
                .latch(port_d_latch[gi]),
                .pullup_en(port_d_pullup_enable[gi]),
                .owned(d_own[gi]),
                .owner_oe(SPI_OE[gi]),
                .owner_out(SPI_OUT[gi]),
                .pin_in(PORT_D_IN[gi]),
                .pin_out(PORT_D_OUT[gi]),
                .pin_oe(PORT_D_OE[gi]),
                .pull_on(PORT_D_PULLUP[gi]),
                .read_bit(d_read[gi])
            );
        end
    endgenerate

    // serial unit takes both port e pins: bit 0 transmits, bit 1 receives
    assign e_own = {2{serial_unit_enable}};
    assign e_owner_oe = 2'b01;
    assign e_owner_out = {1'b0, SERIAL_TX};
    generate
        for (gi = 0; gi < GPDE_E_W; gi = gi + 1) begin : g_port_e
            gpde_pin_cell u_cell (
                .clk(CLK),
                .rst(RST),
                .direction(port_e_direction[gi]),
                .latch(port_e_latch[gi]),
                .pullup_en(1'b0),
                .owned(e_own[gi]),
                .owner_oe(e_owner_oe[gi]),
                .owner_out(e_owner_out[gi]),
                .pin_in(PORT_E_IN[gi]),
                .pin_out(PORT_E_OUT[gi]),
                .pin_oe(PORT_E_OE[gi]),
                .pull_on(e_pull_unused[gi]),
                .read_bit(e_read[gi])
            );
        end
    endgenerate

    // receive data; idle high while the serial unit is off
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SERIAL_RX <= 1'b1;
        end else begin
            SERIAL_RX <= serial_unit_enable ? PORT_E_IN[GPDE_E_RX_BIT]
                : 1'b1;
        end
    end

    // enables to the peripherals, registered
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SERIAL_UNIT_ENABLE <= 1'b0;
            SPI_MODULE_ENABLE <= 1'b0;
        end else begin
            SERIAL_UNIT_ENABLE <= serial_unit_enable;
            SPI_MODULE_ENABLE <= spi_module_enable;
        end
    end

    // read data mux; unmapped reads zero with slverr
    assign rd_byte = {S_AXI_ARADDR[7:2], 2'b00};
    assign rd_hit = gpde_mapped(rd_byte);
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (rd_byte)
            {GPDE_IDX_PORT_D_LATCH[5:0], 2'b00}: begin
                next_rdata[6:0] = d_read;
            end
            {GPDE_IDX_PORT_E_LATCH[5:0], 2'b00}: begin
                next_rdata[1:0] = e_read;
            end
            {GPDE_IDX_PORT_D_DIRECTION[5:0], 2'b00}: begin
                next_rdata[6:0] = port_d_direction;
            end
            {GPDE_IDX_PORT_D_PULLUP[5:0], 2'b00}: begin
                next_rdata[6:0] = port_d_pullup_enable;
            end
            {GPDE_IDX_PORT_E_DIRECTION[5:0], 2'b00}: begin
                next_rdata[1:0] = port_e_direction;
            end
            {GPDE_IDX_PERIPH_ENABLE[5:0], 2'b00}: begin
                next_rdata[1:0] = periph_enable;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // read channel: one wait-free cycle, data held until taken
    // address ready is kept as the inverse of valid, both from flops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= GPDE_RESP_OKAY;
        end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RDATA <= next_rdata;
            S_AXI_RRESP <= rd_hit ? GPDE_RESP_OKAY : GPDE_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // checks
    chk_d_drive_dir: assert property (@(posedge CLK) disable iff (RST)
        (d_own == 7'h00) |=> (PORT_D_OE == $past(port_d_direction)))
        else $error("port d enable not following direction");
    chk_d_reset_dir: assert property (@(posedge CLK)
        $fell(RST) |-> (port_d_direction == 7'h00))
        else $error("port d direction not cleared");
    chk_d_pullup_off: assert property (@(posedge CLK) disable iff (RST)
        ((PORT_D_OE & PORT_D_PULLUP) == 7'h00))
        else $error("pullup on with driver on");
    chk_d_pullup_on: assert property (@(posedge CLK) disable iff (RST)
        (d_own == 7'h00) |=> (PORT_D_PULLUP ==
        ($past(port_d_pullup_enable) & ~$past(port_d_direction))))
        else $error("pullup wrong for input pins");
    chk_e_tx_owned: assert property (@(posedge CLK) disable iff (RST)
        serial_unit_enable |=> (PORT_E_OE == 2'b01
        && PORT_E_OUT[0] == $past(SERIAL_TX)))
        else $error("serial transmit not on port e bit zero");
    chk_e_rx_path: assert property (@(posedge CLK) disable iff (RST)
        serial_unit_enable |=> (SERIAL_RX == $past(PORT_E_IN[1])))
        else $error("receive path broken");
    // drive value judged only where driven: the latch has no reset
    chk_e_gpio_dir: assert property (@(posedge CLK)
        disable iff (RST) !serial_unit_enable |=>
        (PORT_E_OE == $past(port_e_direction)
        && (PORT_E_OUT & PORT_E_OE)
        == $past(port_e_latch & port_e_direction)))
        else $error("port e gpio drive wrong");
    chk_d_read_mux: assert property (@(posedge CLK) disable iff (RST)
        (S_AXI_ARVALID && !S_AXI_RVALID
        && rd_byte == {GPDE_IDX_PORT_D_LATCH[5:0], 2'b00})
        |=> (S_AXI_RDATA[6:0] == (($past(port_d_direction)
        & $past(port_d_latch)) | (~$past(port_d_direction)
        & $past(PORT_D_IN)))))
        else $error("port d read wrong");
    chk_latch_write: assert property (@(posedge CLK) disable iff (RST)
        (wr_go && wr_lane0
        && wr_byte == {GPDE_IDX_PORT_E_LATCH[5:0], 2'b00})
        |=> (port_e_latch == $past(w_data[1:0])))
        else $error("port e latch write lost");
    cov_write: cover property (@(posedge CLK) S_AXI_BVALID && S_AXI_BREADY);
    cov_read: cover property (@(posedge CLK) S_AXI_RVALID && S_AXI_RREADY);
    cov_serial: cover property (@(posedge CLK) serial_unit_enable);
    cov_pullup: cover property (@(posedge CLK) PORT_D_PULLUP != 7'h00);
endmodule

// File: tb/gpde_pin_model.sv
`timescale 1ns/1ps
// board side of the pins: device drivers, board drivers and pullups
module gpde_pin_model
    import gpde_pkg::*;
(
    input wire logic clk, // bus clock
    input wire logic [6:0] d_out, // device drive values, port d
    input wire logic [6:0] d_oe, // device drive enables, port d
    input wire logic [6:0] d_pull, // device pullups, port d
    input wire logic [6:0] ext_d_oe, // board drives port d pin
    input wire logic [6:0] ext_d_val, // board level, port d
    input wire logic [1:0] e_out, // device drive values, port e
    input wire logic [1:0] e_oe, // device drive enables, port e
    input wire logic [1:0] ext_e_oe, // board drives port e pin
    input wire logic [1:0] ext_e_val, // board level, port e
    output logic [6:0] d_in, // resolved port d levels
    output logic [1:0] e_in // resolved port e levels
);
    logic [6:0] d_last = 7'h00;
    logic [1:0] e_last = 2'h0;
    // device wins, then board, then pullup; a floating pin toggles
    // every cycle so a stale level can never pass for a real one
    always_comb begin
        d_in = (d_oe & d_out) | (~d_oe & ext_d_oe & ext_d_val)
            | (~d_oe & ~ext_d_oe & d_pull)
            | (~d_oe & ~ext_d_oe & ~d_pull & ~d_last);
        e_in = (e_oe & e_out) | (~e_oe & ext_e_oe & ext_e_val)
            | (~e_oe & ~ext_e_oe & ~e_last);
    end
    // remember last level for the floating pattern
    always @(posedge clk) begin
        d_last <= d_in;
        e_last <= e_in;
    end
endmodule

// File: tb/gpde_ports_test.sv
`timescale 1ns/1ps
module gpde_ports_test
    import gpde_pkg::*;
;
    localparam logic [7:0] a_dl = GPDE_IDX_PORT_D_LATCH << 2;
    localparam logic [7:0] a_el = GPDE_IDX_PORT_E_LATCH << 2;
    localparam logic [7:0] a_dd = GPDE_IDX_PORT_D_DIRECTION << 2;
    localparam logic [7:0] a_pu = GPDE_IDX_PORT_D_PULLUP << 2;
    localparam logic [7:0] a_ed = GPDE_IDX_PORT_E_DIRECTION << 2;
    localparam logic [7:0] a_en = GPDE_IDX_PERIPH_ENABLE << 2;
    localparam logic [1:0] ok = GPDE_RESP_OKAY;
    localparam logic [1:0] err = GPDE_RESP_SLVERR;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [6:0] d_in, d_out, d_oe, d_pull;
    logic [6:0] spi_own = 7'h00, spi_oe = 7'h00, spi_out = 7'h00;
    logic [6:0] ext_d_oe = 7'h00, ext_d_val = 7'h00;
    logic [1:0] e_in, e_out, e_oe, ext_e_oe = 2'h0, ext_e_val = 2'h0;
    logic ser_tx = 1'b1;
    logic ser_rx, ser_en, spi_en;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;

    gpde_ports dut (.CLK(clk), .RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PORT_D_IN(d_in), .PORT_D_OUT(d_out), .PORT_D_OE(d_oe),
        .PORT_D_PULLUP(d_pull), .PORT_E_IN(e_in), .PORT_E_OUT(e_out),
        .PORT_E_OE(e_oe), .SERIAL_TX(ser_tx), .SERIAL_RX(ser_rx),
        .SPI_OWN(spi_own), .SPI_OE(spi_oe), .SPI_OUT(spi_out),
        .SERIAL_UNIT_ENABLE(ser_en), .SPI_MODULE_ENABLE(spi_en));

    gpde_pin_model pins (.clk(clk), .d_out(d_out), .d_oe(d_oe),
        .d_pull(d_pull), .ext_d_oe(ext_d_oe), .ext_d_val(ext_d_val),
        .e_out(e_out), .e_oe(e_oe), .ext_e_oe(ext_e_oe),
        .ext_e_val(ext_e_val), .d_in(d_in), .e_in(e_in));

    always #25 clk = ~clk;

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a hang ends the run rather than stalling it
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic tend(input string s);
        $display("test %s done, %0d mismatches so far", s, n_fail);
    endtask

    // address and data offered together, response awaited
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
            input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // control registers come up cleared, pins undriven
        rd(a_dd, 32'h0, ok);
        rd(a_ed, 32'h0, ok);
        rd(a_pu, 32'h0, ok);
        rd(a_en, 32'h0, ok);
        chk(32'({d_oe, e_oe, d_pull, ser_rx}), 32'h1);
        tend("reset");
        // port d: pins while inputs, latch once driven
        ext_d_oe <= 7'h7F;
        ext_d_val <= 7'h55;
        rd(a_dl, 32'h0000_0055, ok);
        wr(a_dl, 32'h0000_002A, ok);
        rd(a_dl, 32'h0000_0055, ok);
        wr(a_dd, 32'h0000_000F, ok);
        rd(a_dl, 32'h0000_005A, ok);
        chk(32'(d_oe), 32'h0000_000F);
        chk(32'(d_out & d_oe), 32'h0000_000A);
        tend("port_d");
        // pullups act only on pins that are inputs
        ext_d_oe <= 7'h00;
        wr(a_pu, 32'h0000_0011, ok);
        rd(a_pu, 32'h0000_0011, ok);
        chk(32'(d_pull), 32'h0000_0010);
        wr(a_pu, 32'h0000_007F, ok);
        @(posedge clk);
        chk(32'(d_pull), 32'h0000_0070);
        rd(a_dl, 32'h0000_007A, ok);
        tend("pullup");
        // spi drives its pins, reads still follow direction
        spi_own <= 7'h03;
        spi_oe <= 7'h01;
        spi_out <= 7'h01;
        wr(a_en, 32'h0000_0002, ok);
        @(posedge clk);
        chk(32'(d_oe), 32'h0000_000D);
        chk(32'({d_out & d_oe, spi_en}), 32'h0000_0013);
        rd(a_dl, 32'h0000_007A, ok);
        wr(a_en, 32'h0, ok);
        tend("spi");
        // port e: latch written before direction
        ext_e_oe <= 2'b11;
        ext_e_val <= 2'b10;
        rd(a_el, 32'h0000_0002, ok);
        wr(a_el, 32'h0000_00FF, ok);
        wr(a_ed, 32'h0000_0001, ok);
        rd(a_el, 32'h0000_0003, ok);
        ext_e_oe <= 2'b10;
        chk(32'({e_oe, e_out & e_oe}), 32'h0000_0005);
        tend("port_e");
        // serial unit takes both pins whatever the direction bits say
        ser_tx <= 1'b0;
        wr(a_ed, 32'h0000_0002, ok);
        wr(a_en, 32'h0000_0001, ok);
        @(posedge clk);
        chk(32'({e_oe, e_out & e_oe, ser_rx, ser_en}), 32'h0000_0013);
        rd(a_el, 32'h0000_0002, ok);
        ser_tx <= 1'b1;
        ext_e_val <= 2'b00;
        repeat (2) @(posedge clk);
        chk(32'({e_out[0], ser_rx}), 32'h0000_0002);
        wr(a_en, 32'h0, ok);
        @(posedge clk);
        chk(32'({e_oe, ser_rx, ser_en}), 32'h0000_000A);
        tend("serial");
        // unmapped place: refused and without effect
        wr(8'h30, 32'h0000_0055, err);
        rd(8'h30, 32'h0, err);
        rd(a_dd, 32'h0000_000F, ok);
        tend("unmapped");
        // second reset clears control but keeps the latch
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(a_dd, 32'h0, ok);
        chk(32'(d_oe), 32'h0);
        wr(a_dd, 32'h0000_007F, ok);
        rd(a_dl, 32'h0000_002A, ok);
        tend("reset_again");
        test_done();
    end
endmodule
